// ---- design/pscp_ctrl.sv ----
// Contract
// RQ1 - aux enable inert after reset; mapped outputs only
// RQ2 - enable pin low enables, high disables
// RQ3 - per-loop lock output low when unlocked
// RQ4 - reference lost on crystal fail or absence
// RQ5 - two-bit select picks the stepped loop
// RQ6 - decrement lowers selected loop by one step
// RQ7 - increment raises selected loop by one step
// RQ8 - step size comes from a register
// RQ9 - select 0..3 is a..d; one step per edge; code drops edges that land while busy and up/down edges that rise together
//
// Local design decisions: the APB register port and the register offsets.
module pscp_ctrl
    import pscp_pkg::*;
#(
    parameter int NUM_OUTS = PSCP_NUM_OUTS,
    parameter int FREQ_W = PSCP_FREQ_W,
    parameter int STEP_W = PSCP_STEP_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [PSCP_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // control pins from the board
    input wire logic primary_output_enable_n,
    input wire logic aux_output_enable_n,
    input wire logic [PSCP_SEL_W-1:0] loop_select,
    input wire logic freq_step_up,
    input wire logic freq_step_down,
    input wire logic [1:0] reference_input_pins,
    // internal loop state
    input wire logic [PSCP_NUM_LOOPS-1:0] loop_locked,
    input wire logic xtal_fail,
    // gated clock output enables
    output logic [NUM_OUTS-1:0] clk_out_enable,
    // status pins
    output logic lock_lost_a_n,
    output logic lock_lost_b_n,
    output logic lock_lost_c_n,
    output logic lock_lost_d_n,
    output logic reference_signal_lost_n,
    // per-loop frequency offset words
    output logic [PSCP_NUM_LOOPS-1:0][FREQ_W-1:0] loop_freq_offset,
    // interrupt
    output logic irq
);

    // ************
    // elaboration checks
    // ************
    initial begin
        if (NUM_OUTS < 1 || NUM_OUTS > 8) begin
            $error("NUM_OUTS must be 1 to 8");
        end
        if (STEP_W > FREQ_W || STEP_W > 32) begin
            $error("STEP_W must fit FREQ_W and 32 bits");
        end
        if (FREQ_W > 32) begin
            $error("FREQ_W must be at most 32");
        end
    end

    // ************
    // declarations
    // ************
    logic [7:0] pri_oe_map;             // outputs gated by the primary pin
    logic [7:0] aux_oe_map;             // outputs gated by the aux pin
    logic [STEP_W-1:0] step_size;       // programmable step
    logic [PSCP_NUM_LOOPS-1:0] steer_mode; // per-loop frequency steering enable
    logic [PSCP_IRQ_W-1:0] irq_status;  // sticky events
    logic [PSCP_IRQ_W-1:0] irq_mask;    // 1 lets the event reach irq
    logic [PSCP_IRQ_W-1:0] irq_event;   // this cycle's events
    logic [6:0] pin_sync;               // synced pins
    logic pri_oe_s, aux_oe_s;           // synced enable pins
    logic [1:0] sel_s;                  // synced select
    logic up_s, down_s, ref_s;          // synced step and reference pins
    logic up_prev, down_prev, ref_prev; // previous synced samples
    logic up_rise, down_rise;           // step edges
    logic [PSCP_NUM_LOOPS-1:0] locked_prev;
    logic [$clog2(PSCP_REF_TIMEOUT_CYC+1)-1:0] ref_count; // cycles since last ref edge
    logic ref_absent;                   // no reference edge within timeout
    logic ref_lost;                     // combined reference loss
    logic ref_lost_prev;
    pscp_state_t state;                 // step sequencer
    pscp_state_t next_state;
    pscp_step_req_t step_req;           // captured request
    logic step_apply;                   // one-cycle apply strobe
    logic bus_access;                   // access phase, answer due
    logic bus_write;                    // write takes effect this edge
    logic bus_ok;                       // address hits a register
    logic [31:0] read_mux;              // read data for the address
    logic [5:0] word;                   // word index of paddr
    logic [31:0] status_word;

    // ************
    // pin synchronisers
    // ************
    pscp_sync #(
        .WIDTH(7)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({reference_input_pins[0], freq_step_down, freq_step_up,
                   loop_select, aux_output_enable_n, primary_output_enable_n}),
        .sync_out(pin_sync)
    );

    assign pri_oe_s = pin_sync[0];
    assign aux_oe_s = pin_sync[1];
    assign sel_s = pin_sync[3:2];
    assign up_s = pin_sync[4];
    assign down_s = pin_sync[5];
    assign ref_s = pin_sync[6];

    // ************
    // output enable gating
    // ************
    // an output is enabled only while every pin mapped to it is low;
    // aux map resets to zero so the aux pin gates nothing until configured
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out_enable <= '0;   // outputs held off during reset
        end else begin
            for (int i = 0; i < NUM_OUTS; i++) begin
                clk_out_enable[i] <= ~((pri_oe_map[i] & pri_oe_s)   // RQ2
                                      | (aux_oe_map[i] & aux_oe_s)); // RQ1
            end
        end
    end

    // ************
    // lock status pins
    // ************
    // low while unlocked; reset shows unlocked until loops report
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_lost_a_n <= 1'b0;
            lock_lost_b_n <= 1'b0;
            lock_lost_c_n <= 1'b0;
            lock_lost_d_n <= 1'b0;
            locked_prev <= '0;
        end else begin
            lock_lost_a_n <= loop_locked[0]; // RQ3
            lock_lost_b_n <= loop_locked[1]; // RQ3
            lock_lost_c_n <= loop_locked[2]; // RQ3
            lock_lost_d_n <= loop_locked[3]; // RQ3
            locked_prev <= loop_locked;
        end
    end

    // ************
    // reference activity monitor
    // ************
    // watches one leg of the reference pair; a stuck reference of either
    // level times out. limitation: a reference whose half period exceeds the timeout
    // reads as lost, so the timeout must exceed its half period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev <= 1'b0;
            ref_count <= '0;
        end else begin
            ref_prev <= ref_s;
            if (ref_s != ref_prev) begin
                ref_count <= '0;    // edge seen, restart
            end else if (!ref_absent) begin
                ref_count <= ref_count + 1'b1;
            end
        end
    end

    assign ref_absent = (ref_count >= PSCP_REF_TIMEOUT_CYC[$bits(ref_count)-1:0]);
    assign ref_lost = xtal_fail | ref_absent;

    // pin is active low: low while lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_signal_lost_n <= 1'b1;
            ref_lost_prev <= 1'b0;
        end else begin
            reference_signal_lost_n <= ~ref_lost; // RQ4
            ref_lost_prev <= ref_lost;
        end
    end

    // ************
    // step edge detection
    // ************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_prev <= 1'b0;
            down_prev <= 1'b0;
        end else begin
            up_prev <= up_s;
            down_prev <= down_s;
        end
    end

    // one step per rising edge; both at once cancel out
    assign up_rise = pscp_rise(up_s, up_prev) & ~pscp_rise(down_s, down_prev); // RQ9
    assign down_rise = pscp_rise(down_s, down_prev) & ~pscp_rise(up_s, up_prev); // RQ9

    // ************
    // step sequencer
    // ************
    // idle -> apply -> done -> idle; an edge landing while busy is lost,
    // which bounds the step rate at one per three cycles
    always_comb begin
        next_state = state;
        case (state)
            PSCP_S_IDLE: begin
                if (up_rise || down_rise) begin
                    next_state = PSCP_S_APPLY;
                end
            end
            PSCP_S_APPLY: begin
                next_state = PSCP_S_DONE;
            end
            PSCP_S_DONE: begin
                next_state = PSCP_S_IDLE;
            end
            default: begin
                next_state = PSCP_S_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PSCP_S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // capture direction and loop at the edge; select 0..3 is loop a..d
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_req <= '0;
        end else if (state == PSCP_S_IDLE && (up_rise || down_rise)) begin
            step_req.up <= up_rise;
            step_req.loop <= sel_s; // RQ5 RQ9
        end
    end

    assign step_apply = (state == PSCP_S_APPLY) && steer_mode[step_req.loop];

    // ************
    // frequency offset accumulators
    // ************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_freq_offset <= '0;
        end else if (step_apply) begin
            if (step_req.up) begin
                loop_freq_offset[step_req.loop] <= loop_freq_offset[step_req.loop]
                    + FREQ_W'(step_size); // RQ7 RQ8
            end else begin
                loop_freq_offset[step_req.loop] <= loop_freq_offset[step_req.loop]
                    - FREQ_W'(step_size); // RQ6 RQ8
            end
        end
    end

    // ************
    // interrupt events
    // ************
    always_comb begin
        irq_event = '0;
        irq_event[PSCP_IRQ_STEP] = step_apply;
        irq_event[PSCP_IRQ_LOCK] = |(locked_prev & ~loop_locked);
        irq_event[PSCP_IRQ_REF] = ref_lost & ~ref_lost_prev;
    end

    // sticky bits; a new event wins over a write-one clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else if (bus_write && word == pscp_word(PSCP_OFF_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~pwdata[PSCP_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ************
    // apb slave
    // ************
    // pready rises with the read data one cycle into the access phase; the write lands
    // on the edge the master samples pready high
    assign word = pscp_word(paddr);
    assign bus_access = psel & penable & ~pready;
    assign bus_write = psel & penable & pready & pwrite & ~pslverr;

    always_comb begin
        status_word = '0;
        status_word[PSCP_ST_LOCK_LSB +: PSCP_NUM_LOOPS] = loop_locked;
        status_word[PSCP_ST_REF_LOST] = ref_lost;
        status_word[PSCP_ST_SEL_LSB +: PSCP_SEL_W] = sel_s;
        status_word[PSCP_ST_BUSY] = (state != PSCP_S_IDLE);
    end

    always_comb begin
        read_mux = '0;
        bus_ok = 1'b1;
        case (word)
            pscp_word(PSCP_OFF_PRI_OE_MAP): read_mux[7:0] = pri_oe_map;
            pscp_word(PSCP_OFF_AUX_OE_MAP): read_mux[7:0] = aux_oe_map;
            pscp_word(PSCP_OFF_STEP_SIZE): read_mux[STEP_W-1:0] = step_size;
            pscp_word(PSCP_OFF_STEER_MODE): read_mux[PSCP_NUM_LOOPS-1:0] = steer_mode;
            pscp_word(PSCP_OFF_STATUS): read_mux = status_word;
            pscp_word(PSCP_OFF_IRQ_STATUS): read_mux[PSCP_IRQ_W-1:0] = irq_status;
            pscp_word(PSCP_OFF_IRQ_MASK): read_mux[PSCP_IRQ_W-1:0] = irq_mask;
            pscp_word(PSCP_OFF_FREQ_BASE): read_mux[FREQ_W-1:0] = loop_freq_offset[0];
            pscp_word(PSCP_OFF_FREQ_BASE) + 6'd1: read_mux[FREQ_W-1:0] = loop_freq_offset[1];
            pscp_word(PSCP_OFF_FREQ_BASE) + 6'd2: read_mux[FREQ_W-1:0] = loop_freq_offset[2];
            pscp_word(PSCP_OFF_FREQ_BASE) + 6'd3: read_mux[FREQ_W-1:0] = loop_freq_offset[3];
            default: bus_ok = 1'b0;  // unmapped: error, reads zero
        endcase
    end

    // handshake and read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (bus_access) begin
            pready <= 1'b1;
            pslverr <= ~bus_ok;
            prdata <= pwrite ? 32'h0000_0000 : read_mux;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ************
    // configuration registers
    // ************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pri_oe_map <= PSCP_PRI_MAP_RST;
            aux_oe_map <= PSCP_AUX_MAP_RST; // RQ1
            step_size <= STEP_W'(PSCP_STEP_RST);
            steer_mode <= PSCP_STEER_RST;
            irq_mask <= PSCP_MASK_RST;
        end else if (bus_write) begin
            case (word)
                pscp_word(PSCP_OFF_PRI_OE_MAP): pri_oe_map <= pwdata[7:0];
                pscp_word(PSCP_OFF_AUX_OE_MAP): aux_oe_map <= pwdata[7:0]; // RQ1
                pscp_word(PSCP_OFF_STEP_SIZE): step_size <= pwdata[STEP_W-1:0]; // RQ8
                pscp_word(PSCP_OFF_STEER_MODE): steer_mode <= pwdata[PSCP_NUM_LOOPS-1:0];
                pscp_word(PSCP_OFF_IRQ_MASK): irq_mask <= pwdata[PSCP_IRQ_W-1:0];
                default: ;
            endcase
        end
    end

endmodule

// ---- design/pscp_pkg.sv ----
package pscp_pkg;

    // ************
    // sizes
    // ************
    localparam int PSCP_NUM_LOOPS = 4;      // loops a to d
    localparam int PSCP_NUM_OUTS = 8;       // gated clock outputs
    localparam int PSCP_FREQ_W = 32;        // per-loop frequency offset word
    localparam int PSCP_STEP_W = 24;        // programmable step size
    localparam int PSCP_ADDR_W = 8;         // apb byte address width
    localparam int PSCP_SEL_W = 2;          // loop select width

    // ************
    // register byte offsets
    // ************
    localparam logic [7:0] PSCP_OFF_PRI_OE_MAP = 8'h00;
    localparam logic [7:0] PSCP_OFF_AUX_OE_MAP = 8'h04;
    localparam logic [7:0] PSCP_OFF_STEP_SIZE = 8'h08;
    localparam logic [7:0] PSCP_OFF_STEER_MODE = 8'h0C;
    localparam logic [7:0] PSCP_OFF_STATUS = 8'h10;
    localparam logic [7:0] PSCP_OFF_IRQ_STATUS = 8'h14;
    localparam logic [7:0] PSCP_OFF_IRQ_MASK = 8'h18;
    localparam logic [7:0] PSCP_OFF_FREQ_BASE = 8'h20;  // loop a, then +4 per loop

    // ************
    // reset values
    // ************
    localparam logic [7:0] PSCP_PRI_MAP_RST = 8'hFF;    // primary pin gates all outputs
    localparam logic [7:0] PSCP_AUX_MAP_RST = 8'h00;    // aux pin gates nothing
    localparam logic [23:0] PSCP_STEP_RST = 24'h00_0001;
    localparam logic [3:0] PSCP_STEER_RST = 4'hF;       // steering on for every loop
    localparam logic [2:0] PSCP_MASK_RST = 3'h0;

    // ************
    // field positions
    // ************
    localparam int PSCP_ST_LOCK_LSB = 0;    // status: lock bits [3:0]
    localparam int PSCP_ST_REF_LOST = 4;    // status: reference lost
    localparam int PSCP_ST_SEL_LSB = 5;     // status: synced select [6:5]
    localparam int PSCP_ST_BUSY = 7;        // status: step in flight
    localparam int PSCP_IRQ_W = 3;
    localparam int PSCP_IRQ_STEP = 0;       // a step was applied
    localparam int PSCP_IRQ_LOCK = 1;       // some loop dropped out of lock
    localparam int PSCP_IRQ_REF = 2;        // reference was lost

    // ************
    // timing
    // ************
    localparam int PSCP_CLK_MHZ = 50;
    localparam int PSCP_REF_TIMEOUT_NS = 2000;  // no reference edge this long means lost
    localparam int PSCP_REF_TIMEOUT_CYC = (PSCP_REF_TIMEOUT_NS * PSCP_CLK_MHZ + 999) / 1000;

    // ************
    // types
    // ************
    typedef enum logic [1:0] {
        PSCP_S_IDLE = 2'b00,
        PSCP_S_APPLY = 2'b01,
        PSCP_S_DONE = 2'b11
    } pscp_state_t;

    typedef struct packed {
        logic up;                       // 1 raise, 0 lower
        logic [1:0] loop;               // target loop
    } pscp_step_req_t;

    // rising edge of a synced level
    function automatic logic pscp_rise(input logic cur, input logic prev);
        return cur & ~prev;
    endfunction

    // word index of a byte address
    function automatic logic [5:0] pscp_word(input logic [7:0] addr);
        return addr[7:2];
    endfunction

endpackage

// ---- design/pscp_sync.sv ----
// two-flop synchroniser for pin inputs; first stage feeds only the second
module pscp_sync
    import pscp_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // asynchronous level in, synced level out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;   // metastable stage, read only by stage two

    // ************
    // two stages
    // ************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ---- dv/pscp_ctrl_monitor.sv ----
module pscp_ctrl_monitor
    import pscp_pkg::*;
#(
    parameter int FREQ_W = PSCP_FREQ_W
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // pins and loop state
    input wire logic freq_step_up,
    input wire logic freq_step_down,
    input wire logic [1:0] reference_input_pins,
    input wire logic [PSCP_NUM_LOOPS-1:0] loop_locked,
    input wire logic xtal_fail,
    input wire logic lock_lost_a_n,
    input wire logic lock_lost_b_n,
    input wire logic lock_lost_c_n,
    input wire logic lock_lost_d_n,
    input wire logic reference_signal_lost_n,
    input wire logic [PSCP_NUM_LOOPS-1:0][FREQ_W-1:0] loop_freq_offset
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************
    // reference activity tracking
    // ************
    logic ref_prev; // last seen reference level
    logic [7:0] quiet; // cycles with no reference change, saturating

    // quiet counter; saturates so a long outage never wraps to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_prev <= 1'b0;
            quiet <= 8'h00;
        end else begin
            ref_prev <= reference_input_pins[0];
            if (reference_input_pins[0] != ref_prev) begin
                quiet <= 8'h00;
            end else if (quiet != 8'hff) begin
                quiet <= quiet + 8'h01;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_LOCK_FOLLOW: assert property ($past(presetn) |->
        {lock_lost_d_n, lock_lost_c_n, lock_lost_b_n, lock_lost_a_n} == $past(loop_locked))
        else $error("lock pins do not follow loop lock state");
    AST_XTAL_LOST: assert property (xtal_fail |=> !reference_signal_lost_n)
        else $error("crystal failure not flagged");
    AST_QUIET_LOST: assert property (quiet >= 8'd110 |-> !reference_signal_lost_n)
        else $error("silent reference not flagged");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_READY_CAUSE: assert property (pready |->
        $past(psel && penable) && $past(psel && !penable, 2))
        else $error("pready without setup and one wait state");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_STEP_CAUSE: assert property ($changed(loop_freq_offset) |->
        $past(freq_step_up || freq_step_down, 3))
        else $error("offset moved without a step pin");
    AST_ONE_LOOP: assert property ($changed(loop_freq_offset) |-> $onehot({
        loop_freq_offset[3] != $past(loop_freq_offset[3]),
        loop_freq_offset[2] != $past(loop_freq_offset[2]),
        loop_freq_offset[1] != $past(loop_freq_offset[1]),
        loop_freq_offset[0] != $past(loop_freq_offset[0])}))
        else $error("step touched more than one loop");
    AST_STEP_ONCE: assert property ($changed(loop_freq_offset) |=>
        $stable(loop_freq_offset)[*2])
        else $error("one pin edge gave several steps");

    cover property ($changed(loop_freq_offset));
    cover property (pslverr);
    cover property ($fell(reference_signal_lost_n));
endmodule

bind pscp_ctrl pscp_ctrl_monitor #(.FREQ_W(FREQ_W)) mon (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .freq_step_up, .freq_step_down, .reference_input_pins, .loop_locked,
    .xtal_fail, .lock_lost_a_n, .lock_lost_b_n, .lock_lost_c_n, .lock_lost_d_n,
    .reference_signal_lost_n, .loop_freq_offset);

// ---- dv/pscp_board.sv ----
module pscp_board
    import pscp_pkg::*;
(
    // clock and reference run control
    input wire logic pclk,
    input wire logic ref_run,
    // pins toward the block
    output logic primary_output_enable_n,
    output logic aux_output_enable_n,
    output logic [PSCP_SEL_W-1:0] loop_select,
    output logic freq_step_up,
    output logic freq_step_down,
    output logic [1:0] reference_input_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    // ************
    // board pins
    // ************
    logic [1:0] div; // reference divider

    // idle levels as the pull-downs would leave them, except the reference pair at 2'b10
    initial begin
        primary_output_enable_n = 1'b0;
        aux_output_enable_n = 1'b0;
        loop_select = 2'b00;
        freq_step_up = 1'b0;
        freq_step_down = 1'b0;
        reference_input_pins = 2'b10;
        div = 2'b00;
    end

    // differential reference; a stopped source freezes its level
    always @(posedge pclk) begin
        div <= div + 2'b01;
        if (ref_run && div == 2'b11) begin
            reference_input_pins <= {reference_input_pins[0], ~reference_input_pins[0]};
        end
    end

    // enable pins change just after an edge
    task automatic set_oe(input logic pri, input logic aux);
        @(posedge pclk);
        primary_output_enable_n <= pri;
        aux_output_enable_n <= aux;
    endtask

    // select settles well before the pulse; pulse and gap stay long
    task automatic step(input logic [1:0] sel, input logic up);
        @(posedge pclk);
        loop_select <= sel;
        repeat (4) @(posedge pclk);
        if (up) begin
            freq_step_up <= 1'b1;
        end else begin
            freq_step_down <= 1'b1;
        end
        repeat (4) @(posedge pclk);
        freq_step_up <= 1'b0;
        freq_step_down <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask
endmodule

// ---- dv/test_pscp_ctrl.sv ----
module test_pscp_ctrl
    import pscp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ************
    // bench
    // ************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, exp_off [4];
    logic pready, pslverr, err, pri_n, aux_n, up, dn, irq, ref_n;
    logic [1:0] sel, refp;
    logic [3:0] locked = 4'hf;
    logic xtal_fail = 1'b0;
    logic ref_run = 1'b1;
    logic [7:0] oe;
    logic la, lb, lc, ld;
    logic [3:0][31:0] offs;
    int n_fail = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #10 pclk = ~pclk;

    pscp_board board (.pclk(pclk), .ref_run(ref_run), .primary_output_enable_n(pri_n),
        .aux_output_enable_n(aux_n), .loop_select(sel), .freq_step_up(up),
        .freq_step_down(dn), .reference_input_pins(refp));
    pscp_ctrl uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .primary_output_enable_n(pri_n),
        .aux_output_enable_n(aux_n), .loop_select(sel), .freq_step_up(up),
        .freq_step_down(dn), .reference_input_pins(refp), .loop_locked(locked),
        .xtal_fail(xtal_fail), .clk_out_enable(oe), .lock_lost_a_n(la), .lock_lost_b_n(lb),
        .lock_lost_c_n(lc), .lock_lost_d_n(ld), .reference_signal_lost_n(ref_n),
        .loop_freq_offset(offs), .irq(irq));

    task automatic summarize();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; waits on pready, one wait state expected
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("apb wait", t, 2);
    endtask

    task automatic oe_case(input logic p, input logic a, input logic [7:0] e);
        board.set_oe(p, a);
        repeat (6) @(posedge pclk);
        chk("clk_out_enable", oe, e);
    endtask

    task automatic offs_chk();
        for (int k = 0; k < 4; k++) chk("offset", offs[k], exp_off[k]);
    endtask

    // hang guard, far above the expected run length
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        exp_off = '{default: 32'h0000_0000};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, PSCP_OFF_AUX_OE_MAP, 0);
        chk("aux map reset", rd, 32'h0000_0000);
        apb(1, 8'h40, 32'h1234_5678);
        chk("unmapped err", err, 1);
        oe_case(0, 0, 8'hff);
        oe_case(0, 1, 8'hff);
        oe_case(1, 0, 8'h00);
        apb(1, PSCP_OFF_AUX_OE_MAP, 32'h0000_000f);
        oe_case(0, 1, 8'hf0);
        oe_case(0, 0, 8'hff);
        apb(1, PSCP_OFF_STEP_SIZE, 32'h0000_0100);
        for (int l = 0; l < 4; l++) begin
            board.step(l[1:0], 1'b1);
            exp_off[l] = exp_off[l] + 32'h0000_0100;
            offs_chk();
        end
        apb(1, PSCP_OFF_STEP_SIZE, 32'h0000_0005);
        board.step(2'd2, 1'b0);
        exp_off[2] = exp_off[2] - 32'h0000_0005;
        offs_chk();
        apb(1, PSCP_OFF_STEER_MODE, 32'h0000_000e);
        board.step(2'd0, 1'b1);
        offs_chk();
        apb(0, PSCP_OFF_FREQ_BASE + 8'h08, 0);
        chk("freq c", rd, exp_off[2]);
        chk("irq masked", irq, 0);
        apb(1, PSCP_OFF_IRQ_MASK, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk("irq raised", irq, 1);
        apb(1, PSCP_OFF_IRQ_STATUS, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        chk("irq cleared", irq, 0);
        for (int i = 0; i < 4; i++) begin
            locked <= ~(4'b0001 << i);
            repeat (3) @(posedge pclk);
            chk("lock pins", {ld, lc, lb, la}, locked);
        end
        locked <= 4'hf;
        chk("ref present", ref_n, 1);
        ref_run <= 1'b0;
        repeat (150) @(posedge pclk);
        chk("ref silent", ref_n, 0);
        ref_run <= 1'b1;
        xtal_fail <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("xtal fail", ref_n, 0);
        xtal_fail <= 1'b0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("offset after reset", offs[0], 0);
        summarize();
    end
endmodule
